// ### logic/uamc_mode_control.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Behaviour
// R1 - enabled port drives pins per selection
// R2 - disabled port yields all pins, low power
// R3 - idle-stop halts port during idle
// R4 - infrared bit routes data through codec
// R5 - handshake output mode simplex or flow
// R6 - pin usage 11 and 10 mappings
// R7 - pin usage 01 and 00 mappings
// R8 - wake bit detects start in sleep
// R9 - loopback feeds transmit back internally
// R10 - software avoids access right after disable
// R11 - unimplemented bits read zero, ignore writes
// R12 - implemented bits read write, reset zero
// R13 - write effective next edge, pins switch
module uamc_mode_control
	import uamc_pkg::*;
(
	input  wire logic          ref_clk,
	input  wire logic          rst,
	input  wire uamc_apb_req_t apbReq,
	output uamc_apb_rsp_t      apbRsp,
	input  wire logic          idleMode,
	input  wire logic          sleepMode,
	input  wire logic          serialInPin,
	input  wire logic          clearToSendPin,
	input  wire uamc_pins_t    coreOut,
	input  wire uamc_pins_t    portOut,
	input  wire uamc_pins_t    portOutEn,
	input  wire logic          transmitEnable,
	output uamc_pins_t         pinOut,
	output uamc_pins_t         pinOutEn,
	output logic               coreRxData,
	output logic               coreClearToSend,
	output logic               coreActive,
	output logic               coreClockEnable,
	output logic               infraredEnable,
	output logic               handshakeSimplex,
	output logic               loopbackActive,
	output logic               wakeRequest
);

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [31:0] modeReg_ff;
	logic [31:0] nxt_modeReg;
	uamc_mode_t  mode;
	logic [2:0]  rxSync_ff;
	logic [2:0]  ctsSync_ff;
	logic        rxLevel_ff;
	logic        ctsLevel_ff;
	logic        wake_ff;
	logic        rdSel;
	logic        wrHit;

	function automatic logic [31:0] apply_strobes(input logic [31:0] oldVal,
		input logic [31:0] newVal, input logic [3:0] strb);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return res & UAMC_MODE_WR_MASK; // R11
	endfunction

	// the field struct skips the unimplemented bits, so each field is picked by position
	assign mode = '{enable:           modeReg_ff[UAMC_BIT_ENABLE],
	                idleStop:         modeReg_ff[UAMC_BIT_IDLE_STOP],
	                infraredEnable:   modeReg_ff[UAMC_BIT_INFRARED],
	                handshakeOutMode: modeReg_ff[UAMC_BIT_HS_MODE],
	                pinUsageSelect:   modeReg_ff[UAMC_BIT_PIN_HI:UAMC_BIT_PIN_LO],
	                wakeEnable:       modeReg_ff[UAMC_BIT_WAKE],
	                loopbackSelect:   modeReg_ff[UAMC_BIT_LOOPBACK],
	                lowBits:          modeReg_ff[5:0]};
	assign rdSel = apbReq.psel && (apbReq.paddr == UAMC_MODE_OFFSET);
	assign wrHit = rdSel && apbReq.penable && apbReq.pwrite;

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	// zero wait states keeps the write effective at the access edge
	always_comb begin
		apbRsp.pready  = 1'b1;
		apbRsp.pslverr = apbReq.psel && apbReq.penable && !rdSel;
		apbRsp.prdata  = 32'h0000_0000;
		if (rdSel && !apbReq.pwrite) begin
			apbRsp.prdata = modeReg_ff & UAMC_MODE_WR_MASK; // R11
		end
	end

	always_comb begin
		nxt_modeReg = modeReg_ff;
		if (wrHit) begin
			nxt_modeReg = apply_strobes(modeReg_ff, apbReq.pwdata, apbReq.pstrb); // R12
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			modeReg_ff <= UAMC_MODE_RESET; // R12
		end else begin
			modeReg_ff <= nxt_modeReg; // R13
		end
	end

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	// a change counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rxSync_ff   <= 3'h7;
			ctsSync_ff  <= 3'h7;
			rxLevel_ff  <= 1'b1;
			ctsLevel_ff <= 1'b1;
		end else begin
			rxSync_ff  <= {rxSync_ff[1:0], serialInPin};
			ctsSync_ff <= {ctsSync_ff[1:0], clearToSendPin};
			if (rxSync_ff[1] == rxSync_ff[2]) begin
				rxLevel_ff <= rxSync_ff[2];
			end
			if (ctsSync_ff[1] == ctsSync_ff[2]) begin
				ctsLevel_ff <= ctsSync_ff[2];
			end
		end
	end

	// ---------------------------------------------------------------
	// wake on start bit
	// ---------------------------------------------------------------
	// wake holds until sleep ends or the wake or enable bit clears, so a slow power manager sees it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wake_ff <= 1'b0;
		end else if (!(mode.enable && mode.wakeEnable && sleepMode)) begin
			wake_ff <= 1'b0; // R8
		end else if (!rxLevel_ff) begin
			wake_ff <= 1'b1; // R8
		end
	end

	assign wakeRequest = wake_ff;

	// ---------------------------------------------------------------
	// mode outputs
	// ---------------------------------------------------------------
	assign coreActive       = mode.enable; // R1
	assign coreClockEnable  = mode.enable && !(mode.idleStop && idleMode); // R2 R3
	assign infraredEnable   = mode.enable && mode.infraredEnable; // R4
	assign handshakeSimplex = mode.handshakeOutMode; // R5
	assign loopbackActive   = mode.enable && mode.loopbackSelect; // R9

	// loopback ignores the pin so the far end cannot disturb a self test
	assign coreRxData = loopbackActive ? coreOut.serialOut : rxLevel_ff; // R9

	// ---------------------------------------------------------------
	// pin ownership
	// ---------------------------------------------------------------
	always_comb begin
		uamc_pins_t own;
		own = '0;
		if (mode.enable) begin
			own.serialOut = 1'b1; // R1
			own.serialIn  = 1'b1;
			case (mode.pinUsageSelect)
				UAMC_PINS_TXRX_BCLK: begin
					own.baudClockOut = 1'b1; // R6
				end
				UAMC_PINS_TXRX_FLOW: begin
					own.clearToSend   = 1'b1; // R6
					own.requestToSend = 1'b1;
				end
				UAMC_PINS_TXRX_RTS: begin
					own.requestToSend = 1'b1; // R7
				end
				UAMC_PINS_TXRX: begin
					own = own; // R7
				end
				default: begin
					own = own;
				end
			endcase
		end
		// rts and baud clock have separate pins; the core drives rts for pin usage 01 and 10, and the baud clock only for 11
		pinOut.serialOut     = own.serialOut ? coreOut.serialOut : portOut.serialOut;
		pinOutEn.serialOut   = own.serialOut ? transmitEnable : portOutEn.serialOut; // R1
		pinOut.serialIn      = portOut.serialIn;
		pinOutEn.serialIn    = own.serialIn ? 1'b0 : portOutEn.serialIn;
		pinOut.clearToSend   = portOut.clearToSend;
		pinOutEn.clearToSend = own.clearToSend ? 1'b0 : portOutEn.clearToSend;
		pinOut.requestToSend = own.requestToSend ? coreOut.requestToSend : portOut.requestToSend;
		pinOutEn.requestToSend = own.requestToSend ? 1'b1 : portOutEn.requestToSend;
		pinOut.baudClockOut  = own.baudClockOut ? coreOut.baudClockOut : portOut.baudClockOut;
		pinOutEn.baudClockOut = own.baudClockOut ? 1'b1 : portOutEn.baudClockOut;
		// without the cts pin the core sees permission to send
		coreClearToSend = own.clearToSend ? !ctsLevel_ff : 1'b1; // R6
	end

endmodule

// ### logic/uamc_pkg.sv
package uamc_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [11:0] UAMC_MODE_OFFSET   = 12'h000;
	localparam logic [31:0] UAMC_MODE_RESET    = 32'h0000_0000;
	localparam logic [31:0] UAMC_MODE_WR_MASK  = 32'h0000_BBFF;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int UAMC_BIT_ENABLE    = 15;
	localparam int UAMC_BIT_IDLE_STOP = 13;
	localparam int UAMC_BIT_INFRARED  = 12;
	localparam int UAMC_BIT_HS_MODE   = 11;
	localparam int UAMC_BIT_PIN_HI    = 9;
	localparam int UAMC_BIT_PIN_LO    = 8;
	localparam int UAMC_BIT_WAKE      = 7;
	localparam int UAMC_BIT_LOOPBACK  = 6;

	localparam logic [1:0] UAMC_PINS_TXRX      = 2'h0;
	localparam logic [1:0] UAMC_PINS_TXRX_RTS  = 2'h1;
	localparam logic [1:0] UAMC_PINS_TXRX_FLOW = 2'h2;
	localparam logic [1:0] UAMC_PINS_TXRX_BCLK = 2'h3;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic       enable;
		logic       idleStop;
		logic       infraredEnable;
		logic       handshakeOutMode;
		logic [1:0] pinUsageSelect;
		logic       wakeEnable;
		logic       loopbackSelect;
		logic [5:0] lowBits;
	} uamc_mode_t;

	typedef struct packed {
		logic serialOut;
		logic serialIn;
		logic clearToSend;
		logic requestToSend;
		logic baudClockOut;
	} uamc_pins_t;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} uamc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} uamc_apb_rsp_t;

endpackage

// ### tb/uamc_serial_dev.sv
`timescale 1ns/1ps
module uamc_serial_dev (
	input  wire logic ref_clk,
	input  wire logic sendStart,
	input  wire logic holdOff,
	output logic      serialInPin,
	output logic      clearToSendPin
);
	// idle lines sit high like a pulled-up wire, never left unknown
	initial serialInPin = 1'b1;
	initial clearToSendPin = 1'b1;
	always @(posedge ref_clk) begin
		serialInPin <= !sendStart;
		clearToSendPin <= holdOff;
	end
endmodule

// ### tb/uamc_sva.sv
`timescale 1ns/1ps
module uamc_sva
	import uamc_pkg::*;
(
	input wire logic          ref_clk,
	input wire logic          rst,
	input wire uamc_apb_req_t apbReq,
	input wire uamc_apb_rsp_t apbRsp,
	input wire logic          idleMode,
	input wire uamc_pins_t    portOut,
	input wire uamc_pins_t    portOutEn,
	input wire uamc_pins_t    pinOut,
	input wire uamc_pins_t    pinOutEn,
	input wire logic          coreClearToSend,
	input wire logic          coreActive,
	input wire logic          coreClockEnable,
	input wire logic          infraredEnable,
	input wire logic          loopbackActive
);
	// ----------------
	// shadow register
	// ----------------
	logic [31:0] shadow_ff;
	logic [31:0] msk;
	logic        acc;
	assign acc = apbReq.psel && apbReq.penable && apbReq.paddr == UAMC_MODE_OFFSET;
	assign msk = {{8{apbReq.pstrb[3]}}, {8{apbReq.pstrb[2]}}, {8{apbReq.pstrb[1]}}, {8{apbReq.pstrb[0]}}};
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			shadow_ff <= 32'h0;
		end else if (acc && apbReq.pwrite && apbRsp.pready) begin
			shadow_ff <= (shadow_ff & ~(msk & UAMC_MODE_WR_MASK)) | (apbReq.pwdata & msk & UAMC_MODE_WR_MASK);
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------
	// checks
	// ----------------
	read_back_a: assert property (acc && !apbReq.pwrite |-> apbRsp.prdata == shadow_ff)
		else $error("mode read differs");
	port_active_a: assert property (coreActive == shadow_ff[15])
		else $error("active flag wrong");
	pins_yield_a: assert property (!coreActive |-> pinOut == portOut && pinOutEn == portOutEn)
		else $error("pins not handed over");
	idle_stop_a: assert property (coreClockEnable == (shadow_ff[15] && !(shadow_ff[13] && idleMode)))
		else $error("idle gating wrong");
	codec_on_a: assert property (infraredEnable == (shadow_ff[15] && shadow_ff[12]))
		else $error("codec enable wrong");
	loop_sel_a: assert property (loopbackActive == (shadow_ff[15] && shadow_ff[6]))
		else $error("loopback wrong");
	cts_free_a: assert property (!(shadow_ff[15] && shadow_ff[9:8] == 2'h2) |-> coreClearToSend)
		else $error("send held without flow pins");
	bad_addr_a: assert property (apbReq.psel && apbReq.penable && apbReq.paddr != UAMC_MODE_OFFSET
		|-> apbRsp.pslverr && apbRsp.prdata == 32'h0) else $error("stray access accepted");
endmodule
bind uamc_mode_control uamc_sva u_uamc_sva (.*);

// ### tb/uart_mode_control_tb.sv
`timescale 1ns/1ps
module uart_mode_control_tb
	import uamc_pkg::*;
;
	logic          ref_clk, rst, idleMode, sleepMode, transmitEnable, sendStart, holdOff, er;
	logic          serialInPin, clearToSendPin, coreRxData, coreClearToSend, coreActive, coreClockEnable;
	logic          infraredEnable, handshakeSimplex, loopbackActive, wakeRequest;
	logic [31:0]   rv;
	uamc_apb_req_t apbReq;
	uamc_apb_rsp_t apbRsp;
	uamc_pins_t    coreOut, portOut, portOutEn, pinOut, pinOutEn;
	int            fails, comparisons;
	uamc_mode_control u_uamc_mode_control (.*);
	uamc_serial_dev u_uamc_serial_dev (.*);
	always #2 ref_clk = !ref_clk;
	task automatic close_out();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	// one apb transfer; waits for pready under a bound
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		logic rdy;
		rdy = 1'b0;
		@(posedge ref_clk);
		apbReq <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d, pstrb:4'hF};
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		// answer is read while it stands, then the edge that samples it passes
		do begin
			@(negedge ref_clk);
			rdy = apbRsp.pready;
			rv = apbRsp.prdata;
			er = apbRsp.pslverr;
			@(posedge ref_clk);
			n++;
		end while (rdy !== 1'b1 && n < 16);
		if (rdy !== 1'b1) begin
			fails++;
			close_out();
		end
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		apbReq = '0;
		{idleMode, sleepMode, sendStart, holdOff, transmitEnable} = 5'h03;
		{coreOut, portOut, portOutEn} = 15'h7C1F;
		fails = 0;
		comparisons = 0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		xfer(1'b0, 12'h000, 32'h0);
		chk("reset", rv, 32'h0);
		xfer(1'b1, 12'h000, 32'hFFFFFFFF);
		xfer(1'b0, 12'h000, 32'h0);
		chk("mask", rv, 32'h0000BBFF);
		xfer(1'b0, 12'h004, 32'h0);
		chk("stray_err", er, 1'b1);
		chk("stray_rd", rv, 32'h0);
		xfer(1'b1, 12'h000, 32'h0);
		settle(0);
		chk("pins", {pinOut, pinOutEn}, {portOut, portOutEn});
		chk("active", coreActive, 1'b0);
		for (int v = 0; v < 4; v++) begin
			xfer(1'b1, 12'h000, 32'h8800 | (v << 8));
			settle(4);
			chk("cts", coreClearToSend, v != 2);
			chk("simplex", {coreActive, handshakeSimplex}, 2'h3);
			chk("pinout", pinOut, {3'h4, v == 1 || v == 2, v == 3});
			chk("pinen", pinOutEn, {2'h2, v != 2, 2'h3});
		end
		xfer(1'b1, 12'h000, 32'h8080);
		sleepMode <= 1'b1;
		sendStart <= 1'b1;
		settle(6);
		chk("wake", wakeRequest, 1'b1);
		xfer(1'b1, 12'h000, 32'h8000);
		settle(2);
		chk("nowake", wakeRequest, 1'b0);
		xfer(1'b1, 12'h000, 32'hA000);
		idleMode <= 1'b1;
		settle(1);
		chk("idle", coreClockEnable, 1'b0);
		@(posedge ref_clk);
		idleMode <= 1'b0;
		xfer(1'b1, 12'h000, 32'h9040);
		settle(4);
		chk("loop", {infraredEnable, loopbackActive, coreRxData}, {2'h3, coreOut.serialOut});
		close_out();
	end
endmodule
